// ==== design/adcss_seq.sv ====
/*
 * Scan sequencer and result store for a 12-bit successive-approximation
 * converter: single, continuous and group scans, group A priority with
 * group B rescan, double trigger, addition mode and result registers.
 * Assumes the analog core takes one conversion request per pulse and
 * returns one done pulse with data, both on clk; configuration is static
 * while a scan runs.
 */
// Behaviour
// - Single scan converts each selected input, up to 24, once, then stops.
// - Single scan may target the temperature sensor once.
// - Single scan may target the internal reference once.
// - Continuous scan repeats the selected inputs until stopped.
// - Group scan splits inputs into A and B; a trigger converts its group once.
// - Each group has its own selectable synchronous start trigger.
// - With priority, an A trigger aborts a running B scan and starts A.
// - With priority, B optionally restarts after A completes.
// - Double trigger is allowed only in single or group scan.
// - Double trigger: first result to channel register, second to duplicate.
// - Addition mode sums results, widened by 2 or 4 bits.
// - Results are stored with 12-bit precision.
// - 24 input registers plus temperature, reference and duplicate registers.
// - One self-diagnostic result register per unit.
// - Software, timer, event linker and pulse timer can start a scan.
// - The external trigger pin's falling edge, synchronised to clk, starts a scan.
// - In single scan without double trigger, scan end raises the end request; continuous scan raises none.
// - In double trigger the end request follows both scans.
// - Group A end raises the end request; group B has its own request.
`timescale 1ns/1ns
`default_nettype none

module adcss_seq (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            reset,
	// Configuration and control
	input  wire adcss_pkg::adcss_cfg_t           cfg,
	input  wire logic                            sw_start,
	input  wire logic                            sw_stop,
	// Trigger sources
	input  wire adcss_pkg::adcss_trig_t          trig,
	input  wire logic                            ext_conv_trigger_n,
	// Analog core
	output var  adcss_pkg::adcss_conv_req_t      conv_req,
	output var  logic                            conversion_clock,
	input  wire adcss_pkg::adcss_conv_res_t      conv_res,
	// Results
	output var  logic [adcss_pkg::ADCSS_NUM_CH*adcss_pkg::ADCSS_ACC_W-1:0] result_flat,
	output var  logic [adcss_pkg::ADCSS_ACC_W-1:0] temp_result,
	output var  logic [adcss_pkg::ADCSS_ACC_W-1:0] vref_result,
	output var  logic [adcss_pkg::ADCSS_ACC_W-1:0] dup_result,
	output var  logic [adcss_pkg::ADCSS_RES_W-1:0] diag_result,
	// Status and events
	output var  logic                            busy,
	output var  logic                            cfg_error,
	output var  logic                            scan_end_irq,
	output var  logic                            group_b_scan_end_irq
);
	import adcss_pkg::*;

	// ==========================================================
	// External trigger
	logic ext_fall;

	adcss_ext_sync u_ext (
		.clk                (clk),
		.reset              (reset),
		.ext_conv_trigger_n (ext_conv_trigger_n),
		.fall_pulse         (ext_fall)
	);

	function automatic logic src_hit(input adcss_src_t s, input adcss_trig_t t,
			input logic e);
		case (s)
			ADCSS_SRC_TIMER:  src_hit = t.timer;
			ADCSS_SRC_LINKER: src_hit = t.linker;
			ADCSS_SRC_PULSE:  src_hit = t.pulse;
			ADCSS_SRC_EXTPIN: src_hit = e;
			default:          src_hit = 1'b0;
		endcase
	endfunction

	// Lowest selected channel at or above a start index; bit 5 flags none.
	function automatic logic [ADCSS_CH_W:0] next_sel(input logic [ADCSS_NUM_CH-1:0] sel,
			input logic [ADCSS_CH_W:0] from);
		next_sel = {1'b1, {ADCSS_CH_W{1'b0}}};
		for (int i = ADCSS_NUM_CH - 1; i >= 0; i--) begin
			if (sel[i] && (i >= int'(from)))
				next_sel = {1'b0, ADCSS_CH_W'(i)};
		end
	endfunction

	// ==========================================================
	// Conversion clock divider
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic [3:0] div_max;
	logic       next_cclk;

	always_comb begin
		case (cfg.ratio)
			ADCSS_RATIO_2_1: div_max = ADCSS_DIV_2;
			ADCSS_RATIO_4_1: div_max = ADCSS_DIV_4;
			ADCSS_RATIO_8_1: div_max = ADCSS_DIV_8;
			default:         div_max = ADCSS_DIV_1;
		endcase
		next_div_cnt = (div_cnt + 4'h1 >= div_max) ? 4'h0 : div_cnt + 4'h1;
		next_cclk    = (div_max == ADCSS_DIV_1) ? ~conversion_clock
			: (div_cnt < (div_max >> 1));
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			div_cnt          <= 4'h0;
			conversion_clock <= 1'b0;
		end else begin
			div_cnt          <= next_div_cnt;
			conversion_clock <= next_cclk;
		end
	end

	// ==========================================================
	// Scan sequencer
	typedef enum logic [1:0] {
		ADCSS_ST_IDLE,
		ADCSS_ST_REQ,
		ADCSS_ST_WAIT
	} adcss_state_t;

	adcss_state_t           state, next_state;
	logic                   grp_b, next_grp_b;
	logic                   pend_b, next_pend_b;
	logic                   second, next_second;
	logic [ADCSS_CH_W-1:0]  ch, next_ch;
	logic [ADCSS_ADDCNT_W-1:0] add_cnt, next_add_cnt;
	logic                   next_busy, next_err;
	logic                   next_end, next_bend;
	adcss_conv_req_t        next_req;
	logic [ADCSS_NUM_CH-1:0] sel;
	logic [ADCSS_CH_W:0]    nxt, first_a, first_b, first_cur;
	logic                   trig_a, trig_b, is_inputs, dbl_ok, last_ch;
	logic [ADCSS_ADDCNT_W-1:0] add_need;
	logic                   store;

	always_comb begin
		trig_a = src_hit(cfg.src_a, trig, ext_fall) | sw_start;
		trig_b = src_hit(cfg.src_b, trig, ext_fall);
		dbl_ok = cfg.dbl_trig && (cfg.mode != ADCSS_MODE_CONT);
		is_inputs = (cfg.target == ADCSS_TGT_INPUTS) || (cfg.mode != ADCSS_MODE_SINGLE);
		sel  = (cfg.mode == ADCSS_MODE_GROUP && grp_b) ? cfg.sel_b : cfg.sel_a;
		if (dbl_ok)
			sel = (cfg.mode == ADCSS_MODE_GROUP && grp_b) ? cfg.sel_b
				: (ADCSS_SEL_RST | (24'h000001 << cfg.dbl_ch));
		nxt  = next_sel(sel, {1'b0, ch} + 6'h01);
		// First selected channel of each list; the none flag is dropped when sliced.
		first_a   = next_sel(cfg.sel_a, 6'h00);
		first_b   = next_sel(cfg.sel_b, 6'h00);
		first_cur = next_sel(sel, 6'h00);
		last_ch = nxt[ADCSS_CH_W] || !is_inputs;
		case (cfg.add_mode)
			ADCSS_ADD_2BIT: add_need = ADCSS_ADDCNT_W'(ADCSS_ADD2_CNT - 1);
			ADCSS_ADD_4BIT: add_need = ADCSS_ADDCNT_W'(ADCSS_ADD4_CNT - 1);
			default:        add_need = '0;
		endcase

		next_state   = state;
		next_grp_b   = grp_b;
		next_pend_b  = pend_b;
		next_second  = second;
		next_ch      = ch;
		next_add_cnt = add_cnt;
		next_end     = 1'b0;
		next_bend    = 1'b0;
		next_err     = cfg.dbl_trig && (cfg.mode == ADCSS_MODE_CONT);
		next_req     = '0;
		store        = 1'b0;

		case (state)
			ADCSS_ST_IDLE: begin
				if (trig_a && (cfg.mode != ADCSS_MODE_GROUP || cfg.sel_a != '0)) begin
					next_grp_b  = 1'b0;
					next_second = 1'b0;
					next_state  = ADCSS_ST_REQ;
					next_ch     = (dbl_ok && cfg.mode != ADCSS_MODE_GROUP)
						? first_cur[ADCSS_CH_W-1:0] : first_a[ADCSS_CH_W-1:0];
				end else if ((cfg.mode == ADCSS_MODE_GROUP) && (trig_b || pend_b)) begin
					next_grp_b  = 1'b1;
					next_pend_b = 1'b0;
					next_second = 1'b0;
					next_state  = ADCSS_ST_REQ;
					next_ch     = first_b[ADCSS_CH_W-1:0];
				end
				next_add_cnt = '0;
			end
			ADCSS_ST_REQ: begin
				next_req.start  = 1'b1;
				next_req.ch     = ch;
				next_req.target = is_inputs ? ADCSS_TGT_INPUTS : cfg.target;
				next_state      = ADCSS_ST_WAIT;
			end
			ADCSS_ST_WAIT: begin
				if (conv_res.done) begin
					store = 1'b1;
					if (add_cnt != add_need) begin
						next_add_cnt = add_cnt + 1'b1;
						next_state   = ADCSS_ST_REQ;
					end else if (!last_ch) begin
						next_add_cnt = '0;
						next_ch      = nxt[ADCSS_CH_W-1:0];
						next_state   = ADCSS_ST_REQ;
					end else begin
						next_add_cnt = '0;
						next_ch      = first_cur[ADCSS_CH_W-1:0];
						if (dbl_ok && !second && !grp_b) begin
							next_second = 1'b1;
							next_state  = ADCSS_ST_IDLE;
						end else if (cfg.mode == ADCSS_MODE_CONT && !sw_stop) begin
							next_state  = ADCSS_ST_REQ;
						end else begin
							next_state  = ADCSS_ST_IDLE;
							next_second = 1'b0;
							if (grp_b)
								next_bend = 1'b1;
							else if (cfg.mode != ADCSS_MODE_CONT)
								next_end = 1'b1;
						end
					end
				end
				if (sw_stop && cfg.mode == ADCSS_MODE_CONT)
					next_state = ADCSS_ST_IDLE;
				// Group A preempts a running group B scan.
				if (cfg.mode == ADCSS_MODE_GROUP && cfg.prio_a && grp_b && trig_a) begin
					next_grp_b   = 1'b0;
					next_pend_b  = cfg.rescan_b;
					next_add_cnt = '0;
					next_ch      = first_a[ADCSS_CH_W-1:0];
					next_state   = ADCSS_ST_REQ;
					store        = 1'b0;
				end
			end
			default: next_state = ADCSS_ST_IDLE;
		endcase
		// A second-scan wait in double trigger holds until the next trigger.
		if (state == ADCSS_ST_IDLE && second && !trig_a)
			next_second = second;
		if (state == ADCSS_ST_IDLE && second && trig_a)
			next_second = 1'b1;
		next_busy = (next_state != ADCSS_ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state                <= ADCSS_ST_IDLE;
			grp_b                <= 1'b0;
			pend_b               <= 1'b0;
			second               <= 1'b0;
			ch                   <= '0;
			add_cnt              <= '0;
			busy                 <= 1'b0;
			cfg_error            <= 1'b0;
			scan_end_irq         <= 1'b0;
			group_b_scan_end_irq <= 1'b0;
			conv_req             <= '0;
		end else begin
			state                <= next_state;
			grp_b                <= next_grp_b;
			pend_b               <= next_pend_b;
			second               <= next_second;
			ch                   <= next_ch;
			add_cnt              <= next_add_cnt;
			busy                 <= next_busy;
			cfg_error            <= next_err;
			scan_end_irq         <= next_end;
			group_b_scan_end_irq <= next_bend;
			conv_req             <= next_req;
		end
	end

	// ==========================================================
	// Result registers
	logic [ADCSS_ACC_W-1:0] res [ADCSS_NUM_CH];
	logic [ADCSS_ACC_W-1:0] next_res [ADCSS_NUM_CH];
	logic [ADCSS_ACC_W-1:0] next_temp, next_vref, next_dup, base, sum;
	logic [ADCSS_RES_W-1:0] next_diag;
	logic                   to_dup;

	always_comb begin
		next_res  = res;
		next_temp = temp_result;
		next_vref = vref_result;
		next_dup  = dup_result;
		next_diag = diag_result;
		to_dup    = dbl_ok && second && !grp_b;
		case (is_inputs ? ADCSS_TGT_INPUTS : cfg.target)
			ADCSS_TGT_TEMP: base = temp_result;
			ADCSS_TGT_VREF: base = vref_result;
			default:        base = to_dup ? dup_result : res[ch];
		endcase
		sum = ((add_cnt == '0) ? ADCSS_RES_RST : base)
			+ {{ADCSS_ADD4_W{1'b0}}, conv_res.data};
		if (store) begin
			case (is_inputs ? ADCSS_TGT_INPUTS : cfg.target)
				ADCSS_TGT_TEMP: next_temp = sum;
				ADCSS_TGT_VREF: next_vref = sum;
				ADCSS_TGT_DIAG: next_diag = conv_res.data;
				default: begin
					if (to_dup)
						next_dup = sum;
					else
						next_res[ch] = sum;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < ADCSS_NUM_CH; i++)
				res[i] <= ADCSS_RES_RST;
			temp_result <= ADCSS_RES_RST;
			vref_result <= ADCSS_RES_RST;
			dup_result  <= ADCSS_RES_RST;
			diag_result <= ADCSS_RES_RST[ADCSS_RES_W-1:0];
			result_flat <= '0;
		end else begin
			res         <= next_res;
			temp_result <= next_temp;
			vref_result <= next_vref;
			dup_result  <= next_dup;
			diag_result <= next_diag;
			for (int i = 0; i < ADCSS_NUM_CH; i++)
				result_flat[i*ADCSS_ACC_W +: ADCSS_ACC_W] <= next_res[i];
		end
	end

endmodule

`default_nettype wire

// ==== design/adcss_pkg.sv ====
/*
 * Package for the converter scan sequencer: widths, modes, trigger sources,
 * result layout and the carrier structs shared by the sequencer, the core
 * model and the port checker.
 * Assumes a single 10 MHz peripheral clock and a synchronous active-high reset.
 */
package adcss_pkg;

	// ==========================================================
	// Sizes
	localparam int ADCSS_NUM_CH     = 24;
	localparam int ADCSS_CH_W       = 5;
	localparam int ADCSS_RES_W      = 12;
	localparam int ADCSS_ADD4_W     = 4;
	localparam int ADCSS_ADD2_W     = 2;
	localparam int ADCSS_ACC_W      = ADCSS_RES_W + ADCSS_ADD4_W;
	localparam int ADCSS_ADD2_CNT   = 4;
	localparam int ADCSS_ADD4_CNT   = 16;
	localparam int ADCSS_ADDCNT_W   = 5;

	// ==========================================================
	// Reset values
	localparam logic [ADCSS_ACC_W-1:0]  ADCSS_RES_RST = 16'h0000;
	localparam logic [ADCSS_NUM_CH-1:0] ADCSS_SEL_RST = 24'h000000;

	// ==========================================================
	// Clock ratio codes (peripheral clock : conversion clock)
	typedef enum logic [2:0] {
		ADCSS_RATIO_1_1,
		ADCSS_RATIO_1_2,
		ADCSS_RATIO_2_1,
		ADCSS_RATIO_4_1,
		ADCSS_RATIO_8_1
	} adcss_ratio_t;

	// Conversion-clock divide from the peripheral clock for each ratio.
	localparam logic [3:0] ADCSS_DIV_1 = 4'h1;
	localparam logic [3:0] ADCSS_DIV_2 = 4'h2;
	localparam logic [3:0] ADCSS_DIV_4 = 4'h4;
	localparam logic [3:0] ADCSS_DIV_8 = 4'h8;

	// ==========================================================
	// Modes and targets
	typedef enum logic [1:0] {
		ADCSS_MODE_SINGLE,
		ADCSS_MODE_CONT,
		ADCSS_MODE_GROUP
	} adcss_mode_t;

	typedef enum logic [1:0] {
		ADCSS_TGT_INPUTS,
		ADCSS_TGT_TEMP,
		ADCSS_TGT_VREF,
		ADCSS_TGT_DIAG
	} adcss_target_t;

	typedef enum logic [1:0] {
		ADCSS_SRC_TIMER,
		ADCSS_SRC_LINKER,
		ADCSS_SRC_PULSE,
		ADCSS_SRC_EXTPIN
	} adcss_src_t;

	typedef enum logic [1:0] {
		ADCSS_ADD_OFF,
		ADCSS_ADD_2BIT,
		ADCSS_ADD_4BIT
	} adcss_add_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		adcss_mode_t            mode;
		adcss_target_t          target;
		adcss_ratio_t           ratio;
		adcss_add_t             add_mode;
		logic                   dbl_trig;
		logic [ADCSS_CH_W-1:0]  dbl_ch;
		logic                   prio_a;
		logic                   rescan_b;
		logic [ADCSS_NUM_CH-1:0] sel_a;
		logic [ADCSS_NUM_CH-1:0] sel_b;
		adcss_src_t             src_a;
		adcss_src_t             src_b;
	} adcss_cfg_t;

	typedef struct packed {
		logic timer;
		logic linker;
		logic pulse;
	} adcss_trig_t;

	typedef struct packed {
		logic                   start;
		logic [ADCSS_CH_W-1:0]  ch;
		adcss_target_t          target;
	} adcss_conv_req_t;

	typedef struct packed {
		logic                   done;
		logic [ADCSS_RES_W-1:0] data;
	} adcss_conv_res_t;

endpackage

// ==== design/adcss_ext_sync.sv ====
/*
 * Two-flop synchroniser and falling-edge detector for the external
 * conversion trigger pin.
 * Assumes the pin is asynchronous to clk and held low at least three cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module adcss_ext_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Pin
	input  wire logic ext_conv_trigger_n,
	// Event
	output var  logic fall_pulse
);

	// ==========================================================
	// Synchroniser
	logic meta;
	logic sync;
	logic prev;
	logic next_fall;

	always_comb begin
		next_fall = prev & ~sync;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			meta       <= 1'b1;
			sync       <= 1'b1;
			prev       <= 1'b1;
			fall_pulse <= 1'b0;
		end else begin
			meta       <= ext_conv_trigger_n;
			sync       <= meta;
			prev       <= sync;
			fall_pulse <= next_fall;
		end
	end

endmodule

`default_nettype wire

// ==== test/adcss_core_model.sv ====
/* Behavioural model of the analog converter core behind the sequencer.
   Assumes one request pulse per conversion on clk; answers after lat cycles. */
`timescale 1ns/1ns
`default_nettype none
module adcss_core_model (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset,
	// Stimulus controls
	input  wire logic [11:0]                bias,
	input  wire logic [3:0]                 lat,
	// Converter interface
	input  wire adcss_pkg::adcss_conv_req_t req,
	output var  adcss_pkg::adcss_conv_res_t res
);
	import adcss_pkg::*;
	logic [3:0]  cnt;
	logic [11:0] val;
	logic [11:0] code;
	// ==========================================================
	// Conversion
	assign code = (req.target == ADCSS_TGT_INPUTS) ? {5'h00, req.ch, 2'h0} : {10'h000, req.target};
	// Data flips between answers so a stale sample never matches.
	// A new request restarts the count, as an aborted conversion does.
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt <= 4'h0;
			val <= 12'h000;
			res <= '0;
		end else begin
			res.done <= 1'b0;
			res.data <= ~res.data;
			if (req.start) begin
				cnt <= lat;
				val <= bias + code;
			end else if (cnt == 4'h1) begin
				res.done <= 1'b1;
				res.data <= val;
				cnt <= 4'h0;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/adcss_seq_sva.sv ====
/* Port checker for the scan sequencer.
   Bound to adcss_seq from the testbench top file; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module adcss_seq_sva (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            reset,
	// Observed ports
	input  wire adcss_pkg::adcss_cfg_t           cfg,
	input  wire logic                            sw_start,
	input  wire logic                            ext_conv_trigger_n,
	input  wire adcss_pkg::adcss_conv_req_t      conv_req,
	input  wire adcss_pkg::adcss_conv_res_t      conv_res,
	input  wire logic [adcss_pkg::ADCSS_NUM_CH*adcss_pkg::ADCSS_ACC_W-1:0] result_flat,
	input  wire logic                            busy,
	input  wire logic                            cfg_error,
	input  wire logic                            scan_end_irq,
	input  wire logic                            group_b_scan_end_irq
);
	import adcss_pkg::*;
	logic go_ok;
	logic bad_cfg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ==========================================================
	// Helpers
	assign go_ok = !busy && !cfg_error && cfg.mode == ADCSS_MODE_SINGLE &&
		cfg.target == ADCSS_TGT_INPUTS && (|cfg.sel_a);
	assign bad_cfg = cfg.dbl_trig && cfg.mode == ADCSS_MODE_CONT;
	// ==========================================================
	// Assertions
	start_walk_a: assert property (sw_start && go_ok |=> busy ##1 conv_req.start)
		else $error("software start did not launch a conversion");
	ext_start_a: assert property ($fell(ext_conv_trigger_n) && go_ok &&
		cfg.src_a == ADCSS_SRC_EXTPIN |-> ##[3:8] conv_req.start)
		else $error("pin edge did not launch a conversion");
	start_pulse_a: assert property (conv_req.start |=> !conv_req.start)
		else $error("conversion request longer than one cycle");
	start_in_scan_a: assert property (conv_req.start |-> busy)
		else $error("conversion request outside a scan");
	irq_pulse_a: assert property (scan_end_irq |=> !scan_end_irq)
		else $error("scan end request longer than one cycle");
	single_end_a: assert property (scan_end_irq && cfg.mode == ADCSS_MODE_SINGLE |-> !busy)
		else $error("single scan end while still busy");
	group_b_irq_a: assert property (group_b_scan_end_irq |->
		cfg.mode == ADCSS_MODE_GROUP ##1 !group_b_scan_end_irq)
		else $error("group B end request misplaced");
	err_set_a: assert property (bad_cfg [*2] |-> cfg_error)
		else $error("double trigger in continuous mode not flagged");
	err_clr_a: assert property (!bad_cfg [*2] |-> !cfg_error)
		else $error("configuration error flagged wrongly");
	result_cause_a: assert property ($changed(result_flat) |->
		$past(conv_res.done) || $past(conv_res.done, 2))
		else $error("result changed without a conversion");
	next_req_a: assert property (conv_res.done && busy |->
		##[1:4] (conv_req.start || !busy || scan_end_irq))
		else $error("scan stalled after a conversion");
	// ==========================================================
	// Covers
	cover property (group_b_scan_end_irq);
	cover property (scan_end_irq && cfg.dbl_trig);
	cover property (cfg_error);
	cover property ($fell(ext_conv_trigger_n) ##[1:8] conv_req.start);
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
/* Self-checking testbench for the scan sequencer with a behavioural core.
   Assumes the package, the design, the core model and the checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import adcss_pkg::*;
	// ==========================================================
	// Signals
	logic            clk = 1'b0, reset = 1'b1, sw_start = 1'b0, sw_stop = 1'b0;
	logic            ext_conv_trigger_n = 1'b1;
	logic [11:0]     bias = 12'h100;
	logic [3:0]      lat = 4'h1;
	adcss_cfg_t      cfg = '0, c = '0;
	adcss_trig_t     trig = '0;
	adcss_conv_req_t conv_req;
	adcss_conv_res_t conv_res;
	logic [ADCSS_NUM_CH*ADCSS_ACC_W-1:0] result_flat;
	logic [ADCSS_ACC_W-1:0] temp_result, vref_result, dup_result;
	logic [ADCSS_RES_W-1:0] diag_result;
	logic            conversion_clock, busy, cfg_error, scan_end_irq, group_b_scan_end_irq;
	int              mismatches = 0, n_tests = 0, n_starts = 0, n_irq = 0, n_birq = 0, cycles = 0;
	always #50 clk = ~clk;
	adcss_seq adcss_seq_inst (.clk(clk), .reset(reset), .cfg(cfg), .sw_start(sw_start),
		.sw_stop(sw_stop), .trig(trig), .ext_conv_trigger_n(ext_conv_trigger_n),
		.conv_req(conv_req), .conversion_clock(conversion_clock), .conv_res(conv_res),
		.result_flat(result_flat), .temp_result(temp_result), .vref_result(vref_result),
		.dup_result(dup_result), .diag_result(diag_result), .busy(busy), .cfg_error(cfg_error),
		.scan_end_irq(scan_end_irq), .group_b_scan_end_irq(group_b_scan_end_irq));
	adcss_core_model adcss_core_model_inst (.clk(clk), .reset(reset), .bias(bias), .lat(lat),
		.req(conv_req), .res(conv_res));
	// ==========================================================
	// Monitor and time limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (conv_req.start === 1'b1) n_starts <= n_starts + 1;
		if (scan_end_irq === 1'b1) n_irq <= n_irq + 1;
		if (group_b_scan_end_irq === 1'b1) n_birq <= n_birq + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [15:0] ev(input int ch, input int tgt);
		return {4'h0, bias + 12'(tgt == 0 ? ch * 4 : tgt)};
	endfunction
	function automatic logic [15:0] rf(input int ch);
		return result_flat[ch*16 +: 16];
	endfunction
	task automatic apply;
		@(posedge clk);
		cfg <= c;
		@(posedge clk);
	endtask
	// Source 0 is software, 1 to 3 the timers and linker, 4 the pin.
	task automatic go(input int k);
		@(posedge clk);
		sw_start <= (k == 0);
		trig <= adcss_trig_t'({k == 1, k == 2, k == 3});
		if (k == 4) ext_conv_trigger_n <= 1'b0;
		@(posedge clk);
		sw_start <= 1'b0;
		trig <= '0;
		if (k == 4) repeat (3) @(posedge clk);
		ext_conv_trigger_n <= 1'b1;
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 3000 && (i < 3 || busy !== 1'b0); i++) @(negedge clk);
		check("idle", busy, 16'h0000);
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic next_ch(output logic [4:0] ch);
		for (int i = 0; i < 40 && conv_req.start !== 1'b1; i++) @(negedge clk);
		ch = conv_req.ch;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_single;
		int s, q, h;
		logic p;
		c = '0;
		c.sel_a = 24'h800005;
		c.ratio = ADCSS_RATIO_8_1;
		apply();
		h = 0;
		@(negedge clk);
		p = conversion_clock;
		repeat (16) begin
			@(negedge clk);
			h += (conversion_clock === 1'b1 && p === 1'b0);
			p = conversion_clock;
		end
		check("clock rises", 16'(h), 16'h0002);
		s = n_starts;
		q = n_irq;
		go(0);
		go(0);
		wait_idle();
		check("starts", 16'(n_starts - s), 16'h0003);
		check("end requests", 16'(n_irq - q), 16'h0001);
		check("first", rf(0), ev(0, 0));
		check("last", rf(23), ev(23, 0));
		check("middle", rf(2), ev(2, 0));
		check("unselected", rf(1), 16'h0000);
	endtask
	task automatic t_targets;
		int s;
		logic [15:0] v;
		for (int t = 1; t < 4; t++) begin
			c.target = adcss_target_t'(t);
			apply();
			s = n_starts;
			go(0);
			wait_idle();
			v = t == 1 ? temp_result : t == 2 ? vref_result : {4'h0, diag_result};
			check("target starts", 16'(n_starts - s), 16'h0001);
			check("target result", v, ev(0, t));
		end
	endtask
	task automatic t_sources;
		c = '0;
		c.sel_a = 24'h000010;
		for (int k = 1; k < 5; k++) begin
			c.src_a = adcss_src_t'(k - 1);
			lat <= 4'(k * 3);
			bias <= 12'(k * 256);
			apply();
			go(k);
			wait_idle();
			check("source result", rf(4), ev(4, 0));
		end
	endtask
	task automatic t_cont;
		int s;
		c = '0;
		c.mode = ADCSS_MODE_CONT;
		c.sel_a = 24'h000003;
		lat <= 4'h1;
		apply();
		s = n_starts;
		go(0);
		for (int i = 0; i < 400 && n_starts - s < 6; i++) @(negedge clk);
		@(posedge clk);
		sw_stop <= 1'b1;
		@(posedge clk);
		sw_stop <= 1'b0;
		wait_idle();
		check("repeats", 16'(n_starts - s >= 6), 16'h0001);
		s = n_starts;
		repeat (20) @(negedge clk);
		check("stopped", 16'(n_starts - s), 16'h0000);
	endtask
	task automatic t_group;
		int q, b;
		logic [4:0] ch;
		c = '0;
		c.mode = ADCSS_MODE_GROUP;
		c.sel_a = 24'h000001;
		c.sel_b = 24'h000F00;
		c.src_a = ADCSS_SRC_LINKER;
		c.src_b = ADCSS_SRC_TIMER;
		c.prio_a = 1'b1;
		c.rescan_b = 1'b1;
		lat <= 4'h6;
		bias <= 12'h500;
		apply();
		q = n_irq;
		b = n_birq;
		go(1);
		next_ch(ch);
		check("group B first", ch, 16'h0008);
		go(2);
		next_ch(ch);
		check("preempt", ch, 16'h0000);
		wait_idle();
		// Busy drops for one cycle between the A end and the B rescan.
		wait_idle();
		check("A end", 16'(n_irq - q), 16'h0001);
		check("B end", 16'(n_birq - b), 16'h0001);
		check("A result", rf(0), ev(0, 0));
		check("B rescan", rf(11), ev(11, 0));
	endtask
	task automatic t_double;
		int q;
		c = '0;
		c.dbl_trig = 1'b1;
		c.dbl_ch = 5'h03;
		c.sel_a = 24'h000008;
		lat <= 4'h2;
		bias <= 12'h200;
		apply();
		q = n_irq;
		go(0);
		wait_idle();
		check("end after one", 16'(n_irq - q), 16'h0000);
		bias <= 12'h300;
		go(0);
		wait_idle();
		check("end after two", 16'(n_irq - q), 16'h0001);
		check("first copy", rf(3), 16'h020C);
		check("second copy", dup_result, 16'h030C);
	endtask
	task automatic t_add;
		c = '0;
		c.sel_a = 24'h000020;
		bias <= 12'h400;
		for (int m = 1; m < 3; m++) begin
			c.add_mode = adcss_add_t'(m);
			apply();
			go(0);
			wait_idle();
			check("sum", rf(5), 16'(ev(5, 0) * (m == 1 ? ADCSS_ADD2_CNT : ADCSS_ADD4_CNT)));
		end
	endtask
	task automatic t_cfgerr;
		c = '0;
		c.mode = ADCSS_MODE_CONT;
		c.dbl_trig = 1'b1;
		apply();
		@(negedge clk);
		check("bad mix", cfg_error, 16'h0001);
		c.mode = ADCSS_MODE_GROUP;
		apply();
		@(negedge clk);
		check("good mix", cfg_error, 16'h0000);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_single();
		t_targets();
		t_sources();
		t_cont();
		t_group();
		t_double();
		t_add();
		t_cfgerr();
		wrap_up();
	end
endmodule
bind adcss_seq adcss_seq_sva adcss_seq_sva_inst (.clk(clk), .reset(reset), .cfg(cfg),
	.sw_start(sw_start), .ext_conv_trigger_n(ext_conv_trigger_n), .conv_req(conv_req),
	.conv_res(conv_res), .result_flat(result_flat), .busy(busy), .cfg_error(cfg_error),
	.scan_end_irq(scan_end_irq), .group_b_scan_end_irq(group_b_scan_end_irq));
`default_nettype wire
